/* shared/ida_defines.svh */
// Purpose : constants for the indirect data memory access block
// Assumes : 10-bit data memory address, sector in the upper bits
// Notes   : offsets are special-area locations within sector 0
`ifndef IDA_DEFINES_SVH
`define IDA_DEFINES_SVH

// ****************************************************************
// address layout
// ****************************************************************
`define IDA_ADDR_W        10
`define IDA_SECT_W        2
`define IDA_DATA_W        8
`define IDA_RAM_IDX_W     9
`define IDA_SECT_MSB      9
`define IDA_SECT_LSB      8
`define IDA_SPECIAL_TOP   8'h7f
`define IDA_SPLIT_BIT     7
`define IDA_ZERO_BYTE     8'h00

// ****************************************************************
// special-area offsets, sector 0
// ****************************************************************
`define IDA_OFS_PORT_S0   8'h00
`define IDA_OFS_PTR_S0    8'h01
`define IDA_OFS_PORT_A    8'h02
`define IDA_OFS_PTR_A_LO  8'h03
`define IDA_OFS_PTR_A_SEC 8'h04
`define IDA_OFS_PORT_B    8'h0c
`define IDA_OFS_PTR_B_LO  8'h0d
`define IDA_OFS_PTR_B_SEC 8'h0e

// ****************************************************************
// reset values
// ****************************************************************
`define IDA_PTR_RST       8'h00

`endif

/* shared/ida_pkg.sv */
// Purpose : types shared by the indirect access block
// Assumes : ida_defines.svh holds the numbers
// Notes   : decode target kinds only
`default_nettype none

package ida_pkg;

  // ****************************************************************
  // decode target of one data memory address
  // ****************************************************************
  typedef enum logic [3:0] {
    IDA_TGT_NONE     = 4'b0000,  // unused special location
    IDA_TGT_PORT_S0  = 4'b0001,  // sector-0 indirect port
    IDA_TGT_PORT_A   = 4'b0010,  // indirect port a
    IDA_TGT_PORT_B   = 4'b0011,  // indirect port b
    IDA_TGT_PTR_S0   = 4'b0100,  // sector-0 pointer
    IDA_TGT_PTR_A_LO = 4'b0101,  // pointer a low byte
    IDA_TGT_PTR_A_SC = 4'b0110,  // pointer a sector byte
    IDA_TGT_PTR_B_LO = 4'b0111,  // pointer b low byte
    IDA_TGT_PTR_B_SC = 4'b1000,  // pointer b sector byte
    IDA_TGT_RAM      = 4'b1001   // general purpose storage
  } ida_tgt_e;

endpackage

`default_nettype wire

/* src/ida_ram.sv */
// Purpose : general purpose storage, upper half of every sector
// Assumes : one write port, one combinational read port
// Notes   : contents are data and are not reset
`default_nettype none
`include "ida_defines.svh"

module ida_ram
  import ida_pkg::*;
(
  input  wire logic                        clk,    // system clock
  input  wire logic                        ce,     // clock enable
  input  wire logic                        we,     // write strobe
  input  wire logic [`IDA_RAM_IDX_W-1:0]   widx,   // write index
  input  wire logic [`IDA_DATA_W-1:0]      wdata,  // write byte
  input  wire logic [`IDA_RAM_IDX_W-1:0]   ridx,   // read index
  output logic      [`IDA_DATA_W-1:0]      rdata   // read byte
);

  localparam int DEPTH = 1 << `IDA_RAM_IDX_W;

  logic [`IDA_DATA_W-1:0] mem_q [DEPTH];  // storage array

  // ****************************************************************
  // write port
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem_q[widx] <= wdata;
    end
  end

  // read port, combinational
  assign rdata = mem_q[ridx];

endmodule

`default_nettype wire

/* src/ida_core.sv */
// Purpose : indirect data memory access with memory pointers
// Assumes : core issues one access per cycle on the same clock
// Notes   : other special registers live outside; they read 00 here
//
// Functional notes
// - port access goes to pointed memory location
// - sector-0 port reaches sector 0 only
// - ports a and b pick sector by pointer
// - ports read 00H, writes do nothing
// - five pointer bytes behave as registers
// - wide direct address spans all sectors
// - pointer low byte gives in-sector location
// - 00H-7FH special, upper half general storage
`default_nettype none
`include "ida_defines.svh"

module ida_core
  import ida_pkg::*;
(
  input  wire logic                     clk,          // system clock
  input  wire logic                     nrst,         // async reset, active low
  input  wire logic                     ce,           // clock enable, freezes state
  input  wire logic [`IDA_ADDR_W-1:0]   core_addr,    // operand address, sector in top
  input  wire logic                     core_rd,      // read request
  input  wire logic                     core_wr,      // write request
  input  wire logic [`IDA_DATA_W-1:0]   core_wdata,   // write byte
  output logic      [`IDA_DATA_W-1:0]   core_rdata,   // read byte, registered
  output logic                          core_rvalid,  // read answer pulse
  output logic                          core_claim,   // block owned the last read
  output logic      [`IDA_ADDR_W-1:0]   eff_addr,     // last resolved address
  output logic      [`IDA_DATA_W-1:0]   ptr_s0,       // sector-0 pointer value
  output logic      [`IDA_DATA_W-1:0]   ptr_a_low,    // pointer a low byte
  output logic      [`IDA_DATA_W-1:0]   ptr_a_sector, // pointer a sector byte
  output logic      [`IDA_DATA_W-1:0]   ptr_b_low,    // pointer b low byte
  output logic      [`IDA_DATA_W-1:0]   ptr_b_sector  // pointer b sector byte
);

  // ****************************************************************
  // decode function
  // ****************************************************************

  // classify one full address; used for the operand and the result
  function automatic ida_tgt_e ida_decode(input logic [`IDA_ADDR_W-1:0] a);
    logic [`IDA_SECT_W-1:0] sec;
    logic [`IDA_DATA_W-1:0] ofs;
    sec = a[`IDA_SECT_MSB:`IDA_SECT_LSB];
    ofs = a[`IDA_DATA_W-1:0];
    if (ofs[`IDA_SPLIT_BIT]) begin
      return IDA_TGT_RAM;
    end
    // pointer and port locations are decoded in sector 0 only
    if (sec != '0) begin
      return IDA_TGT_NONE;
    end
    unique case (ofs)
      `IDA_OFS_PORT_S0:   return IDA_TGT_PORT_S0;
      `IDA_OFS_PTR_S0:    return IDA_TGT_PTR_S0;
      `IDA_OFS_PORT_A:    return IDA_TGT_PORT_A;
      `IDA_OFS_PTR_A_LO:  return IDA_TGT_PTR_A_LO;
      `IDA_OFS_PTR_A_SEC: return IDA_TGT_PTR_A_SC;
      `IDA_OFS_PORT_B:    return IDA_TGT_PORT_B;
      `IDA_OFS_PTR_B_LO:  return IDA_TGT_PTR_B_LO;
      `IDA_OFS_PTR_B_SEC: return IDA_TGT_PTR_B_SC;
      default:            return IDA_TGT_NONE;  // other special registers
    endcase
  endfunction

  // true for the three ports without storage
  function automatic logic ida_is_port(input ida_tgt_e t);
    return (t == IDA_TGT_PORT_S0) || (t == IDA_TGT_PORT_A) || (t == IDA_TGT_PORT_B);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [`IDA_DATA_W-1:0]   ptr_s0_q;     // sector-0 pointer
  logic [`IDA_DATA_W-1:0]   ptr_a_lo_q;   // pointer a low
  logic [`IDA_DATA_W-1:0]   ptr_a_sc_q;   // pointer a sector
  logic [`IDA_DATA_W-1:0]   ptr_b_lo_q;   // pointer b low
  logic [`IDA_DATA_W-1:0]   ptr_b_sc_q;   // pointer b sector
  logic [`IDA_DATA_W-1:0]   rdata_q;      // read answer byte
  logic                     rvalid_q;     // read answer pulse
  logic                     claim_q;      // read owned by block
  logic [`IDA_ADDR_W-1:0]   eff_q;        // last resolved address

  // ****************************************************************
  // address formation
  // ****************************************************************
  ida_tgt_e                 op_tgt;       // target of operand address
  ida_tgt_e                 res_tgt;      // target after pointer lookup
  logic [`IDA_ADDR_W-1:0]   res_addr;     // resolved full address
  logic [`IDA_DATA_W-1:0]   rd_byte;      // byte to answer
  logic                     rd_claim;     // block owns this read
  logic [`IDA_DATA_W-1:0]   ram_rdata;    // storage read byte
  logic                     ram_we;       // storage write strobe

  assign op_tgt = ida_decode(core_addr);

  // pick the address the access really goes to
  always_comb begin
    res_addr = core_addr;
    unique case (op_tgt)
      IDA_TGT_PORT_S0: res_addr = {{`IDA_SECT_W{1'b0}}, ptr_s0_q};
      IDA_TGT_PORT_A:  res_addr = {ptr_a_sc_q[`IDA_SECT_W-1:0], ptr_a_lo_q};
      IDA_TGT_PORT_B:  res_addr = {ptr_b_sc_q[`IDA_SECT_W-1:0], ptr_b_lo_q};
      default:         res_addr = core_addr;
    endcase
  end

  assign res_tgt = ida_decode(res_addr);

  // read byte selection from the resolved target
  always_comb begin
    rd_byte  = `IDA_ZERO_BYTE;
    rd_claim = 1'b1;
    unique case (res_tgt)
      IDA_TGT_PTR_S0:   rd_byte = ptr_s0_q;
      IDA_TGT_PTR_A_LO: rd_byte = ptr_a_lo_q;
      IDA_TGT_PTR_A_SC: rd_byte = ptr_a_sc_q;
      IDA_TGT_PTR_B_LO: rd_byte = ptr_b_lo_q;
      IDA_TGT_PTR_B_SC: rd_byte = ptr_b_sc_q;
      IDA_TGT_RAM:      rd_byte = ram_rdata;
      IDA_TGT_PORT_S0,
      IDA_TGT_PORT_A,
      IDA_TGT_PORT_B:   rd_byte = `IDA_ZERO_BYTE;
      // another block answers
      default: begin
        rd_byte  = `IDA_ZERO_BYTE;
        rd_claim = 1'b0;
      end
    endcase
  end

  assign ram_we = core_wr && (res_tgt == IDA_TGT_RAM) && !ida_is_port(res_tgt);

  // ****************************************************************
  // storage
  // ****************************************************************
  ida_ram u_ram (
    .clk   (clk),
    .ce    (ce),
    .we    (ram_we),
    .widx  ({res_addr[`IDA_SECT_MSB:`IDA_SECT_LSB], res_addr[`IDA_SPLIT_BIT-1:0]}),
    .wdata (core_wdata),
    .ridx  ({res_addr[`IDA_SECT_MSB:`IDA_SECT_LSB], res_addr[`IDA_SPLIT_BIT-1:0]}),
    .rdata (ram_rdata)
  );

  // ****************************************************************
  // pointer registers
  // ****************************************************************

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ptr_s0_q   <= `IDA_PTR_RST;
      ptr_a_lo_q <= `IDA_PTR_RST;
      ptr_a_sc_q <= `IDA_PTR_RST;
      ptr_b_lo_q <= `IDA_PTR_RST;
      ptr_b_sc_q <= `IDA_PTR_RST;
    end else if (ce && core_wr) begin
      unique case (res_tgt)
        IDA_TGT_PTR_S0:   ptr_s0_q   <= core_wdata;
        IDA_TGT_PTR_A_LO: ptr_a_lo_q <= core_wdata;
        IDA_TGT_PTR_A_SC: ptr_a_sc_q <= core_wdata;
        IDA_TGT_PTR_B_LO: ptr_b_lo_q <= core_wdata;
        IDA_TGT_PTR_B_SC: ptr_b_sc_q <= core_wdata;
        default: begin
          // no pointer hit, keep all
        end
      endcase
    end
  end

  // ****************************************************************
  // read answer
  // ****************************************************************

  // answer one cycle after the read request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q  <= `IDA_ZERO_BYTE;
      rvalid_q <= 1'b0;
      claim_q  <= 1'b0;
    end else if (ce) begin
      rvalid_q <= core_rd;
      if (core_rd) begin
        rdata_q <= rd_byte;
        claim_q <= rd_claim;
      end
    end
  end

  // resolved address of each access, for trace
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eff_q <= '0;
    end else if (ce && (core_rd || core_wr)) begin
      eff_q <= res_addr;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign core_rdata   = rdata_q;
  assign core_rvalid  = rvalid_q;
  assign core_claim   = claim_q;
  assign eff_addr     = eff_q;
  assign ptr_s0       = ptr_s0_q;
  assign ptr_a_low    = ptr_a_lo_q;
  assign ptr_a_sector = ptr_a_sc_q;
  assign ptr_b_low    = ptr_b_lo_q;
  assign ptr_b_sector = ptr_b_sc_q;

endmodule

`default_nettype wire

/* test/ida_core_properties.sv */
// Purpose : port-level checks of the indirect access block
// Assumes : one clock, async active-low reset
// Notes   : bound into every ida_core
`default_nettype none
module ida_core_chk (
  input wire logic       clk,          // system clock
  input wire logic       nrst,         // reset, active low
  input wire logic       ce,           // clock enable
  input wire logic [9:0] core_addr,    // operand address
  input wire logic       core_rd,      // read request
  input wire logic       core_wr,      // write request
  input wire logic [7:0] core_wdata,   // write byte
  input wire logic [7:0] core_rdata,   // read byte
  input wire logic       core_rvalid,  // read answer
  input wire logic       core_claim,   // owned flag
  input wire logic [9:0] eff_addr,     // resolved address
  input wire logic [7:0] ptr_s0,       // sector-0 pointer
  input wire logic [7:0] ptr_a_low,    // pointer a low
  input wire logic [7:0] ptr_a_sector, // pointer a sector
  input wire logic [7:0] ptr_b_low,    // pointer b low
  input wire logic [7:0] ptr_b_sector  // pointer b sector
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       go;     // an access is taken
  logic [9:0] res_a;  // address pointed by pair a
  logic [9:0] res_b;  // address pointed by pair b
  assign go    = ce && (core_rd || core_wr);
  assign res_a = {ptr_a_sector[1:0], ptr_a_low};
  assign res_b = {ptr_b_sector[1:0], ptr_b_low};
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rvalid_after_read: assert property (ce && core_rd |=> core_rvalid)
    else $error("read answer missing");
  a_rvalid_stays_low: assert property (ce && !core_rd |=> !core_rvalid)
    else $error("read answer without read");
  a_port_s0_sector: assert property (go && core_addr == 10'h000
    |=> eff_addr == {2'b00, $past(ptr_s0)}) else $error("sector-0 port left sector 0");
  a_port_a_route: assert property (go && core_addr == 10'h002
    |=> eff_addr == $past(res_a)) else $error("port a resolved wrongly");
  a_port_b_route: assert property (go && core_addr == 10'h00c
    |=> eff_addr == $past(res_b)) else $error("port b resolved wrongly");
  a_direct_wide_addr: assert property (go && core_addr[7]
    |=> eff_addr == $past(core_addr)) else $error("direct address altered");
  a_pointer_store: assert property (ce && core_wr && core_addr == 10'h003
    |=> ptr_a_low == $past(core_wdata)) else $error("pointer write lost");
  a_upper_special_zero: assert property (ce && core_rd && core_addr[9:8] != 2'b00
    && !core_addr[7] |=> core_rdata == 8'h00 && !core_claim) else $error("special read");
  a_pointer_next_use: assert property (ce && core_wr && core_addr == 10'h001
    ##1 go && core_addr == 10'h000 |=> eff_addr == {2'b00, $past(core_wdata, 2)})
    else $error("new pointer not used at once");
  a_freeze_on_hold: assert property (!ce |=> $stable(eff_addr) && $stable(ptr_s0))
    else $error("state moved while disabled");
  c_port_a: cover property (go && core_addr == 10'h002);
  c_stall_read: cover property (ce && core_rd ##1 !ce);
  c_port_zero: cover property (core_rvalid && core_claim && core_rdata == 8'h00);
  c_ptr_then_port: cover property (ce && core_wr && core_addr == 10'h001
    ##1 go && core_addr == 10'h000);
endmodule
bind ida_core ida_core_chk u_chk (.clk(clk), .nrst(nrst), .ce(ce), .core_addr(core_addr),
  .core_rd(core_rd), .core_wr(core_wr), .core_wdata(core_wdata), .core_rdata(core_rdata),
  .core_rvalid(core_rvalid), .core_claim(core_claim), .eff_addr(eff_addr), .ptr_s0(ptr_s0),
  .ptr_a_low(ptr_a_low), .ptr_a_sector(ptr_a_sector), .ptr_b_low(ptr_b_low),
  .ptr_b_sector(ptr_b_sector));
`default_nettype wire

/* test/ida_cpu_model.sv */
// Purpose : processor core side, issues one access per call
// Assumes : requests taken on an enabled rising edge
// Notes   : unused lines carry scrambled values
`default_nettype none
module ida_cpu_model (
  input  wire logic       clk,        // system clock
  output var  logic       ce,         // clock enable
  output var  logic [9:0] core_addr,  // operand address
  output var  logic       core_rd,    // read request
  output var  logic       core_wr,    // write request
  output var  logic [7:0] core_wdata  // write byte
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet values before the first call
  initial begin
    ce = 1'b0;
    core_addr = 10'h000;
    core_rd = 1'b0;
    core_wr = 1'b0;
    core_wdata = 8'h00;
  end
  // present a request, optionally one frozen cycle first
  task automatic issue(input logic [9:0] a, input logic r, w, input logic [7:0] d,
                       input logic st);
    for (int k = st ? 0 : 1; k < 2; k++) begin
      @(posedge clk);
      ce <= (k == 1);
      core_addr <= (r || w) ? a : ~a;
      core_rd <= r;
      core_wr <= w;
      core_wdata <= w ? d : ~d;
    end
  endtask
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Purpose : self-checking bench for the indirect access block
// Assumes : core model drives requests, bench keeps a reference map
// Notes   : random traffic over the sector-0 port, port a, pointers and storage
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ida_pkg::*;
  // ****************************************************************
  // signals and reference state
  // ****************************************************************
  logic clk = 1'b0, nrst = 1'b0, ce, rd, wr, rv, cl, ce_seen = 1'b0;
  logic [9:0] addr, eff;
  logic [7:0] wd, rdat, p0, pal, pas, pbl, pbs, m[1024], e0, e1, e2, e3, e4;
  logic [31:0] seed = 32'h00000043, r;
  logic [8:0] q[$], x;
  int n_mismatch = 0, compares = 0;
  initial forever #2 clk = ~clk;
  ida_cpu_model u_cpu (.clk(clk), .ce(ce), .core_addr(addr), .core_rd(rd), .core_wr(wr),
    .core_wdata(wd));
  ida_core DUT (.clk(clk), .nrst(nrst), .ce(ce), .core_addr(addr), .core_rd(rd),
    .core_wr(wr), .core_wdata(wd), .core_rdata(rdat), .core_rvalid(rv), .core_claim(cl),
    .eff_addr(eff), .ptr_s0(e0), .ptr_a_low(e1), .ptr_a_sector(e2), .ptr_b_low(e3),
    .ptr_b_sector(e4));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [39:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one access: note the answer, update the map, then issue it
  task automatic op(input logic [9:0] a, input logic rq, w, input logic [7:0] d, input logic st);
    logic [9:0] e;
    e = (a == 10'h000) ? {2'b00, p0} : (a == 10'h002) ? {pas[1:0], pal} :
        (a == 10'h00c) ? {pbs[1:0], pbl} : a;
    x = 9'h000;
    if (e[7]) x = {1'b1, m[e]};
    else if (e[9:8] == 2'b00) begin
      case (e[7:0])
        8'h00, 8'h02, 8'h0c: x = 9'h100;
        8'h01: x = {1'b1, p0};
        8'h03: x = {1'b1, pal};
        8'h04: x = {1'b1, pas};
        8'h0d: x = {1'b1, pbl};
        8'h0e: x = {1'b1, pbs};
        default: x = 9'h000;
      endcase
    end
    if (rq) q.push_back(x);
    if (w && e[7]) m[e] = d;
    if (w && e[9:8] == 2'b00) begin
      case (e[7:0])
        8'h01: p0 = d;
        8'h03: pal = d;
        8'h04: pas = d;
        8'h0d: pbl = d;
        8'h0e: pbs = d;
        default: ;
      endcase
    end
    u_cpu.issue(a, rq, w, d, st);
  endtask
  // compare each fresh read answer with the oldest note
  always @(posedge clk) ce_seen <= ce;
  always @(negedge clk) begin
    if (nrst && ce_seen && rv === 1'b1) begin
      x = (q.size() != 0) ? q.pop_front() : 9'h0ff;
      chk({31'h0, cl, rdat}, {31'h0, x});
    end
  end
  task automatic tally_and_finish();
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {p0, pal, pas, pbl, pbs} = 40'h0;
    repeat (20) @(posedge clk);
    chk({e0, e1, e2, e3, e4}, 40'h0);
    nrst <= 1'b1;
    for (int i = 0; i < 512; i++) begin
      r = xs();
      op({i[8:7], 1'b1, i[6:0]}, 1'b0, 1'b1, r[7:0], 1'b0);
    end
    // directed walk: pointer written then used on the very next access
    op(10'h001, 1'b0, 1'b1, 8'h85, 1'b0);
    op(10'h000, 1'b1, 1'b0, 8'h00, 1'b0);
    // pair a set to sector 1, location f0, then reached through port a
    op(10'h004, 1'b0, 1'b1, 8'h01, 1'b0);
    op(10'h003, 1'b0, 1'b1, 8'hf0, 1'b0);
    op(10'h002, 1'b0, 1'b1, 8'h55, 1'b0);
    op(10'h002, 1'b1, 1'b0, 8'h00, 1'b0);
    op(10'h1f0, 1'b1, 1'b0, 8'h00, 1'b0);
    // read and write in one access after a frozen cycle: old byte back, new byte stored
    op(10'h002, 1'b1, 1'b1, 8'haa, 1'b1);
    op(10'h1f0, 1'b1, 1'b0, 8'h00, 1'b0);
    // sector-0 port write lands in storage at 085, then the sector-0 pointer is read back
    op(10'h000, 1'b0, 1'b1, 8'h3c, 1'b0);
    op(10'h001, 1'b1, 1'b0, 8'h00, 1'b0);
    for (int i = 0; i < 1500; i++) begin
      r = xs();
      case (r[3:0])
        4'h0, 4'h1, 4'h2: addr_pick(10'h000 | {7'h0, r[10:8]});
        4'h3, 4'h4, 4'h5: addr_pick(r[13:12] == 2'b00 ? 10'h002 : 10'h00c + {8'h0, r[13:12]});
        4'h6, 4'h7: addr_pick({r[9:8], 1'b0, r[14:8]});
        default: addr_pick({r[9:8], 1'b1, r[22:16]});
      endcase
    end
    op(10'h000, 1'b0, 1'b0, 8'h00, 1'b0);
    for (int i = 0; i < 8 && q.size() != 0; i++) @(posedge clk);
    if (q.size() != 0) n_mismatch++;
    chk({e0, e1, e2, e3, e4}, {p0, pal, pas, pbl, pbs});
    tally_and_finish();
  end
  // random access with stalls and read plus write
  task automatic addr_pick(input logic [9:0] a);
    op(a, r[4], r[5], r[31:24], r[7:6] == 2'b00);
  endtask
endmodule
`default_nettype wire
